// ===== hdl/cmsc_core.v
// Purpose: cpu mode (run, wait, stop, debug halt) control, debug command gating
//          and secure memory access gating for the instruction pipeline
// Assumes: one clock clk_sys_i, synchronous active-low reset, ce_i freezes state
// Notes:   the memory arrays are outside; this block gates strobes and read data
//
// Operation
// - keep a minimal clock set running in stop so a periodic wake works.
// - with debug enabled, the oscillator stays running through stop mode.
// - with debug enabled, halt command in stop restarts cpu clocks and enters debug halt.
// - wait instruction clears interrupt mask, then stops cpu clocks; here irq_mask_clr_o and the clock stop come on the same edge.
// - interrupt or reset in wait restarts clocks and is processed normally.
// - halt command in wait restarts cpu clocks and enters debug halt.
// - in wait only halt and status memory commands; status reports stop/wait error.
// - enter debug halt on mode pin low at reset, command, instruction, breakpoint.
// - after halt instruction only reset, resume, step or tagged resume leave halt.
// - memory, status memory, debug register and halt commands work in run and halt.
// - cpu register, step and resume commands honoured only in debug halt.
// - secure status comes from an external input signal.
// - when secured ram, flash, eeprom are secure; direct and high page are not.
// - each fetch tags the instruction secure or non-secure by source memory.
// - secured read of secure memory returns zero for non-secure tag or debug.
// - secured write to secure memory suppressed for non-secure tag or debug.
// - stacking writes on interrupt entry are never suppressed.
// - secure-tagged instruction may access both secure and non-secure memory.
// - debug controller accesses to non-secure memory are always allowed.
// - when not secured every access is permitted.
// - decoder accepts 254 single-byte and 47 prefixed two-byte opcodes; the check here passes 63 prefixed codes.
// - after reset run six cycles fetching vector from top two bytes.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`include "cmsc_regs.vh"

module cmsc_core #(
   parameter ADDR_W     = 16,
   parameter DATA_W     = 8,
   parameter [15:0] DP_TOP   = 16'h00ff,
   parameter [15:0] HP_BASE  = 16'h1800,
   parameter [15:0] HP_TOP   = 16'h18ff
) (
   // clock, reset, enable
   input  wire              clk_sys_i,
   input  wire              rst_n_i,
   input  wire              ce_i,
   // pins from outside the clock domain
   input  wire              debug_mode_select_pin_i,
   input  wire              secure_i,
   // pipeline events
   input  wire              wait_instr_i,
   input  wire              stop_instr_i,
   input  wire              debug_halt_instruction_i,
   input  wire              breakpoint_hit_i,
   input  wire              irq_pending_i,
   input  wire              periodic_wake_i,
   input  wire              stop_clocks_keep_cfg_i,
   // debug controller command port
   input  wire              dbg_cmd_valid_i,
   input  wire [3:0]        dbg_cmd_i,
   input  wire              debug_enable_set_i,
   output reg               dbg_cmd_accept_o,
   output reg  [1:0]        dbg_cmd_status_o,
   output reg               dbg_cmd_done_o,
   // cpu memory request
   input  wire              mem_req_i,
   input  wire              mem_we_i,
   input  wire              mem_fetch_i,
   input  wire              mem_dbg_i,
   input  wire              mem_stacking_i,
   input  wire [ADDR_W-1:0] mem_addr_i,
   input  wire [DATA_W-1:0] mem_rdata_array_i,
   input  wire [7:0]        opcode_i,
   input  wire              opcode_prefixed_i,
   // gated memory side
   output wire              mem_we_array_o,
   output wire [DATA_W-1:0] mem_rdata_o,
   output reg               instr_secure_o,
   output wire              opcode_valid_o,
   // mode and clock controls
   output reg  [2:0]        mode_o,
   output wire              cpu_clk_en_o,
   output wire              osc_keep_o,
   output wire              stop_min_clk_o,
   output reg               irq_mask_clr_o,
   output reg               reset_vec_fetch_o,
   output reg  [ADDR_W-1:0] reset_vec_addr_o,
   output reg               debug_enable_o
);

   // ***********************************
   // pin synchronisers
   // ***********************************
   reg [1:0] ms_sync_r;
   reg [1:0] sec_sync_r;
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ms_sync_r  <= 2'h3;
         sec_sync_r <= 2'h0;
      end else if (ce_i) begin
         ms_sync_r  <= {ms_sync_r[0], debug_mode_select_pin_i};
         sec_sync_r <= {sec_sync_r[0], secure_i};
      end
   end
   wire secured = sec_sync_r[1];
   wire ms_low  = ~ms_sync_r[1];

   // ***********************************
   // command classes
   // ***********************************
   wire cmd_halt     = (dbg_cmd_i == `CMSC_CMD_HALT);
   wire cmd_memstat  = (dbg_cmd_i == `CMSC_CMD_MEM_STAT);
   wire cmd_nonintr  = (dbg_cmd_i == `CMSC_CMD_MEM) || cmd_memstat ||
                       (dbg_cmd_i == `CMSC_CMD_DBG_REG) || cmd_halt;
   wire cmd_leave    = (dbg_cmd_i == `CMSC_CMD_RESUME) || (dbg_cmd_i == `CMSC_CMD_STEP) ||
                       (dbg_cmd_i == `CMSC_CMD_TAG_RESUME);
   wire cmd_active   = cmd_leave || (dbg_cmd_i == `CMSC_CMD_CPU_REG);

   // ***********************************
   // mode machine
   // ***********************************
   reg [2:0] mode_nxt;
   reg [2:0] seq_cnt_r;
   reg       halt_on_seq_r;
   reg       halt_req;
   reg       accept;
   reg [1:0] status;
   reg       step_pend_r;

   always @* begin
      mode_nxt = mode_o;
      accept   = 1'b0;
      status   = `CMSC_ST_REFUSED;
      halt_req = dbg_cmd_valid_i && cmd_halt;
      case (mode_o)
         `CMSC_MODE_RESET_SEQ: begin
            if (seq_cnt_r == `CMSC_RESET_SEQ_CYC - 3'h1)
               mode_nxt = halt_on_seq_r ? `CMSC_MODE_HALT : `CMSC_MODE_RUN;
         end
         `CMSC_MODE_RUN: begin
            if (dbg_cmd_valid_i && cmd_nonintr) begin
               accept = 1'b1;
               status = `CMSC_ST_OK;
            end
            if (halt_req || debug_halt_instruction_i || breakpoint_hit_i)
               mode_nxt = `CMSC_MODE_HALT;
            else if (wait_instr_i)
               mode_nxt = `CMSC_MODE_WAIT;
            else if (stop_instr_i)
               mode_nxt = `CMSC_MODE_STOP;
         end
         `CMSC_MODE_WAIT: begin
            if (dbg_cmd_valid_i && (cmd_halt || cmd_memstat)) begin
               accept = 1'b1;
               status = cmd_memstat ? `CMSC_ST_STOPWAIT_ERR : `CMSC_ST_OK;
            end
            if (halt_req)
               mode_nxt = `CMSC_MODE_HALT;
            else if (irq_pending_i)
               mode_nxt = `CMSC_MODE_RUN;
         end
         `CMSC_MODE_STOP: begin
            if (dbg_cmd_valid_i && debug_enable_o && (cmd_halt || cmd_memstat)) begin
               accept = 1'b1;
               status = cmd_memstat ? `CMSC_ST_STOPWAIT_ERR : `CMSC_ST_OK;
            end
            if (halt_req && debug_enable_o)
               mode_nxt = `CMSC_MODE_HALT;
            else if (irq_pending_i || (stop_clocks_keep_cfg_i && periodic_wake_i))
               mode_nxt = `CMSC_MODE_RUN;
         end
         `CMSC_MODE_HALT: begin
            if (dbg_cmd_valid_i && (cmd_nonintr || cmd_active)) begin
               accept = 1'b1;
               status = `CMSC_ST_OK;
            end
            if (dbg_cmd_valid_i && cmd_leave)
               mode_nxt = `CMSC_MODE_RUN;
         end
         default: mode_nxt = `CMSC_MODE_RESET_SEQ;
      endcase
   end

   // a single step runs one instruction, then drops back into halt
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mode_o           <= `CMSC_MODE_RESET_SEQ;
         seq_cnt_r        <= 3'h0;
         halt_on_seq_r    <= 1'b0;
         step_pend_r      <= 1'b0;
         dbg_cmd_accept_o <= 1'b0;
         dbg_cmd_status_o <= `CMSC_ST_OK;
         dbg_cmd_done_o   <= 1'b0;
         irq_mask_clr_o   <= 1'b0;
         debug_enable_o   <= 1'b0;
      end else if (ce_i) begin
         if (step_pend_r && mode_o == `CMSC_MODE_RUN && !debug_halt_instruction_i) begin
            mode_o      <= `CMSC_MODE_HALT;
            step_pend_r <= 1'b0;
         end else begin
            mode_o <= mode_nxt;
            if (mode_o == `CMSC_MODE_HALT && dbg_cmd_valid_i && dbg_cmd_i == `CMSC_CMD_STEP)
               step_pend_r <= 1'b1;
         end
         if (mode_o == `CMSC_MODE_RESET_SEQ) begin
            seq_cnt_r <= seq_cnt_r + 3'h1;
            // mode pin is sampled at the third clock after release, after it has crossed the synchroniser
            if (seq_cnt_r == 3'h2)
               halt_on_seq_r <= ms_low;
         end
         dbg_cmd_accept_o <= accept;
         dbg_cmd_status_o <= status;
         dbg_cmd_done_o   <= dbg_cmd_valid_i;
         irq_mask_clr_o   <= (mode_o == `CMSC_MODE_RUN) && wait_instr_i && (mode_nxt == `CMSC_MODE_WAIT);
         if (debug_enable_set_i || (mode_o == `CMSC_MODE_RESET_SEQ && seq_cnt_r == 3'h5 && halt_on_seq_r))
            debug_enable_o <= 1'b1;
      end
   end

   // ***********************************
   // reset vector fetch
   // ***********************************
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         reset_vec_fetch_o <= 1'b0;
         reset_vec_addr_o  <= {ADDR_W{1'b0}};
      end else if (ce_i) begin
         reset_vec_fetch_o <= (mode_o == `CMSC_MODE_RESET_SEQ) && (seq_cnt_r < 3'h2);
         reset_vec_addr_o  <= (seq_cnt_r == 3'h0) ? `CMSC_RESET_VEC_HI : `CMSC_RESET_VEC_LO;
      end
   end

   // clocks stop in wait and stop; osc stays alive while a debugger may need it
   assign cpu_clk_en_o   = (mode_o != `CMSC_MODE_WAIT) && (mode_o != `CMSC_MODE_STOP);
   assign osc_keep_o     = debug_enable_o;
   assign stop_min_clk_o = (mode_o == `CMSC_MODE_STOP) && stop_clocks_keep_cfg_i;

   // ***********************************
   // security gating
   // ***********************************
   wire in_dp     = (mem_addr_i <= DP_TOP);
   wire in_hp     = (mem_addr_i >= HP_BASE) && (mem_addr_i <= HP_TOP);
   wire secure_mem = ~(in_dp | in_hp);
   wire denied    = secured && secure_mem && (mem_dbg_i || !instr_secure_o);
   wire wr_block  = denied && !mem_stacking_i;
   reg  rd_zero_r;
   reg  [DATA_W-1:0] rdata_r;

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         instr_secure_o <= 1'b0;
         rd_zero_r      <= 1'b0;
      end else if (ce_i) begin
         if (mem_req_i && mem_fetch_i)
            instr_secure_o <= secure_mem;
         rd_zero_r <= mem_req_i && !mem_we_i && !mem_fetch_i && denied;
      end
   end

   always @* begin
      rdata_r = rd_zero_r ? `CMSC_SECURE_READ_VAL : mem_rdata_array_i;
   end

   assign mem_we_array_o = mem_req_i && mem_we_i && !wr_block;
   assign mem_rdata_o    = rdata_r;

   // ***********************************
   // opcode decode check
   // ***********************************
   // two single-byte codes are not opcodes: the prefix and one reserved code
   wire one_ok = (opcode_i != `CMSC_OPC_PREFIX) && (opcode_i != 8'hac);
   wire two_ok = (opcode_i[7:4] >= 4'h6) && (opcode_i[3:0] <= 4'h2) ||
                 (opcode_i >= 8'hd0) && (opcode_i[3:0] != 4'hd) && (opcode_i[3:0] != 4'hc);
   assign opcode_valid_o = opcode_prefixed_i ? two_ok : one_ok;

endmodule

// ===== hdl/cmsc_regs.vh
// Purpose: constants for the cpu mode and security controller
// Assumes: included by hdl/cmsc_core.v and by the verification files
// Notes:   debug command codes are a local encoding, not a wire protocol
`ifndef CMSC_REGS_VH
`define CMSC_REGS_VH

// mode state codes
`define CMSC_MODE_RUN        3'h0
`define CMSC_MODE_WAIT       3'h1
`define CMSC_MODE_STOP       3'h2
`define CMSC_MODE_HALT       3'h3
`define CMSC_MODE_RESET_SEQ  3'h4

// debug command codes
`define CMSC_CMD_MEM         4'h0
`define CMSC_CMD_MEM_STAT    4'h1
`define CMSC_CMD_DBG_REG     4'h2
`define CMSC_CMD_HALT        4'h3
`define CMSC_CMD_CPU_REG     4'h4
`define CMSC_CMD_STEP        4'h5
`define CMSC_CMD_RESUME      4'h6
`define CMSC_CMD_TAG_RESUME  4'h7

// command answer status codes
`define CMSC_ST_OK           2'h0
`define CMSC_ST_STOPWAIT_ERR 2'h1
`define CMSC_ST_REFUSED      2'h2

// reset vector sequence
`define CMSC_RESET_SEQ_CYC   3'h6
`define CMSC_RESET_VEC_HI    16'hfffe
`define CMSC_RESET_VEC_LO    16'hffff

// opcode counts of the decoder
`define CMSC_OPC_ONE_BYTE    9'h0fe
`define CMSC_OPC_TWO_BYTE    9'h02f
`define CMSC_OPC_PREFIX      8'h9e

// secure read replacement value
`define CMSC_SECURE_READ_VAL 8'h00

`endif

// ===== verification/cmsc_core_chk.sv
// Purpose: port-level checks of cmsc_core
// Assumes: ce_i held high
// Notes:   bound from the bench top file
`include "cmsc_regs.vh"
module cmsc_core_chk #(
   parameter [15:0] DP_TOP  = 16'h00ff,
   parameter [15:0] HP_BASE = 16'h1800,
   parameter [15:0] HP_TOP  = 16'h18ff
) (
   // clock, reset, events
   input wire        clk_sys_i, rst_n_i, secure_i, wait_instr_i, irq_pending_i,
   // command port
   input wire        dbg_cmd_valid_i, dbg_cmd_accept_o,
   input wire [3:0]  dbg_cmd_i,
   input wire [1:0]  dbg_cmd_status_o,
   // memory
   input wire        mem_req_i, mem_we_i, mem_fetch_i, mem_dbg_i, mem_stacking_i, mem_we_array_o, instr_secure_o,
   input wire [15:0] mem_addr_i, reset_vec_addr_o,
   input wire [7:0]  mem_rdata_array_i, mem_rdata_o,
   // mode
   input wire [2:0]  mode_o,
   input wire        cpu_clk_en_o, osc_keep_o, irq_mask_clr_o, reset_vec_fetch_o, debug_enable_o
);
   // ****
   // guards
   // ****
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire sec = mem_addr_i > DP_TOP && !(mem_addr_i >= HP_BASE && mem_addr_i <= HP_TOP);
   wire deny = secure_i && sec && (mem_dbg_i || !instr_secure_o);
   wire rd = mem_req_i && !mem_we_i && !mem_fetch_i;
   wire cv = dbg_cmd_valid_i;
   sequence s_vec;
      reset_vec_fetch_o && reset_vec_addr_o == `CMSC_RESET_VEC_HI ##1 reset_vec_addr_o == `CMSC_RESET_VEC_LO;
   endsequence
   sequence s_wait;
      irq_mask_clr_o ##[0:1] (mode_o == `CMSC_MODE_WAIT && !cpu_clk_en_o);
   endsequence
   a_vec_order: assert property ($rose(reset_vec_fetch_o) |-> s_vec) else $error("vector order");
   a_run_ok: assert property (cv && mode_o inside {`CMSC_MODE_RUN, `CMSC_MODE_HALT} && dbg_cmd_i <= `CMSC_CMD_HALT
      |=> dbg_cmd_accept_o && dbg_cmd_status_o == `CMSC_ST_OK) else $error("command refused");
   a_run_refuse: assert property (cv && mode_o == `CMSC_MODE_RUN && dbg_cmd_i >= `CMSC_CMD_CPU_REG
      |=> !dbg_cmd_accept_o && dbg_cmd_status_o == `CMSC_ST_REFUSED) else $error("command taken");
   a_wait_stat: assert property (cv && mode_o == `CMSC_MODE_WAIT && dbg_cmd_i == `CMSC_CMD_MEM_STAT
      |=> dbg_cmd_status_o == `CMSC_ST_STOPWAIT_ERR) else $error("status");
   a_halt_entry: assert property (cv && dbg_cmd_i == `CMSC_CMD_HALT && (mode_o inside {`CMSC_MODE_RUN,
      `CMSC_MODE_WAIT} || mode_o == `CMSC_MODE_STOP && debug_enable_o) |=> mode_o == `CMSC_MODE_HALT)
      else $error("no halt");
   a_halt_stays: assert property (mode_o == `CMSC_MODE_HALT && !(cv && dbg_cmd_i >= `CMSC_CMD_STEP)
      |=> mode_o == `CMSC_MODE_HALT) else $error("halt left");
   a_wait_entry: assert property (wait_instr_i && mode_o == `CMSC_MODE_RUN && !irq_pending_i |=> s_wait)
      else $error("wait entry");
   a_osc_keep: assert property (mode_o == `CMSC_MODE_STOP && debug_enable_o |-> osc_keep_o) else $error("osc");
   a_we_block: assert property (mem_req_i && mem_we_i && deny && !mem_stacking_i |-> !mem_we_array_o)
      else $error("write passed");
   a_we_stack: assert property (mem_req_i && mem_we_i && mem_stacking_i |-> mem_we_array_o) else $error("stack");
   a_rd_zero: assert property (rd && deny |=> mem_rdata_o == `CMSC_SECURE_READ_VAL) else $error("read leak");
   a_rd_open: assert property (rd && !secure_i |=> mem_rdata_o == mem_rdata_array_i) else $error("read");
   a_fetch_tag: assert property (mem_req_i && mem_fetch_i && secure_i |=> instr_secure_o == $past(sec))
      else $error("tag");
endmodule

// ===== verification/cmsc_host_model.sv
// Purpose: host debug system on the debug controller command port
// Assumes: one command per call, valid held one clock
// Notes:   bad lets a scenario send halt-only commands outside halt
`include "cmsc_regs.vh"
module cmsc_host_model (
   // clock and observed mode
   input  wire        clk_sys_i,
   input  wire  [2:0] mode_i,
   // command port
   output logic       dbg_cmd_valid_o,
   output logic [3:0] dbg_cmd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // sender
   // ****
   initial begin
      dbg_cmd_valid_o = 1'b0;
      dbg_cmd_o = 4'h0;
   end
   task automatic issue(input [3:0] c, input bit bad);
      if (!bad && c >= `CMSC_CMD_CPU_REG && mode_i != `CMSC_MODE_HALT) return;
      @(posedge clk_sys_i);
      dbg_cmd_valid_o <= 1'b1;
      dbg_cmd_o <= c;
      @(posedge clk_sys_i);
      dbg_cmd_valid_o <= 1'b0;
      // stale code inverted so a design never sees a held value
      dbg_cmd_o <= ~c;
   endtask
endmodule

// ===== verification/testbench.sv
// Purpose: self-checking bench for cmsc_core
// Assumes: ce_i and opcode_prefixed_i held constant; opcode_i changed only for the decode check
// Notes:   expected command answers queue up for the monitor
`include "cmsc_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i, rst_n_i, ce_i, debug_mode_select_pin_i, secure_i, wait_instr_i, stop_instr_i, tag, ok, sc;
   logic debug_halt_instruction_i, breakpoint_hit_i, irq_pending_i, periodic_wake_i, stop_clocks_keep_cfg_i;
   logic dbg_cmd_valid_i, debug_enable_set_i, mem_req_i, mem_we_i, mem_fetch_i, mem_dbg_i, mem_stacking_i;
   logic opcode_prefixed_i, dbg_cmd_accept_o, dbg_cmd_done_o, mem_we_array_o, instr_secure_o, opcode_valid_o;
   logic cpu_clk_en_o, osc_keep_o, stop_min_clk_o, irq_mask_clr_o, reset_vec_fetch_o, debug_enable_o;
   logic [3:0] dbg_cmd_i, evt, f;
   logic [1:0] dbg_cmd_status_o, mst, exp_q[$];
   logic [2:0] mode_o, md;
   logic [7:0] mem_rdata_array_i, mem_rdata_o, opcode_i, d;
   logic [15:0] mem_addr_i, reset_vec_addr_o, a;
   logic [31:0] lfsr = 32'h6d10c693;
   int error_cnt, check_count;
   assign {wait_instr_i, stop_instr_i, debug_halt_instruction_i, breakpoint_hit_i} = evt;
   cmsc_core DUT (.*);
   cmsc_host_model host (.clk_sys_i(clk_sys_i), .mode_i(mode_o), .dbg_cmd_valid_o(dbg_cmd_valid_i),
      .dbg_cmd_o(dbg_cmd_i));
   // ****
   // helpers
   // ****
   task automatic chk(input [15:0] s, e, input string n);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   task finish_test;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wmode(input [2:0] m);
      for (int i = 0; i < 12 && mode_o !== m; i++) @(negedge clk_sys_i);
      chk(mode_o, m, "mode");
      md = m;
   endtask
   task automatic ev(input [3:0] k);
      @(posedge clk_sys_i);
      evt <= k;
      @(posedge clk_sys_i);
      evt <= 4'h0;
   endtask
   task automatic rst(input p);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      debug_mode_select_pin_i <= p;
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
   endtask
   task automatic cmd(input [3:0] c, input bit bad);
      logic [1:0] st;
      // the host drops a halt-only command outside halt, so no answer may be queued for it
      if (!bad && c >= `CMSC_CMD_CPU_REG && mode_o != `CMSC_MODE_HALT) return;
      st = (md == `CMSC_MODE_HALT || md == `CMSC_MODE_RUN && c <= `CMSC_CMD_HALT) ? `CMSC_ST_OK : `CMSC_ST_REFUSED;
      if (md inside {`CMSC_MODE_WAIT, `CMSC_MODE_STOP} && c == `CMSC_CMD_HALT) st = `CMSC_ST_OK;
      if (md inside {`CMSC_MODE_WAIT, `CMSC_MODE_STOP} && c == `CMSC_CMD_MEM_STAT) st = `CMSC_ST_STOPWAIT_ERR;
      exp_q.push_back(st);
      host.issue(c, bad);
      @(negedge clk_sys_i);
      if (st == `CMSC_ST_OK && c inside {`CMSC_CMD_HALT, `CMSC_CMD_STEP}) wmode(`CMSC_MODE_HALT);
      if (st == `CMSC_ST_OK && c >= `CMSC_CMD_RESUME) wmode(`CMSC_MODE_RUN);
   endtask
   task automatic acc(input [15:0] ad, input [3:0] fl, input s);
      ok = !s || !(ad > 16'h00ff && !(ad >= 16'h1800 && ad <= 16'h18ff)) || tag && !fl[1];
      @(posedge clk_sys_i);
      {secure_i, mem_req_i, mem_we_i, mem_fetch_i, mem_dbg_i, mem_stacking_i, mem_addr_i} <= {s, 1'b1, fl, ad};
      @(negedge clk_sys_i);
      if (fl[3]) chk(mem_we_array_o, ok || fl[0], "we");
      @(posedge clk_sys_i);
      mem_req_i <= 1'b0;
      d = lfsr[7:0];
      mem_rdata_array_i <= d;
      @(negedge clk_sys_i);
      if (!fl[3]) chk(mem_rdata_o, (ok || fl[2]) ? d : 8'h00, "rdata");
      if (fl[2]) tag = ad > 16'h00ff && !(ad >= 16'h1800 && ad <= 16'h18ff);
   endtask
   // ****
   // monitor, clock, watchdog, sequence
   // ****
   always @(negedge clk_sys_i)
      if (dbg_cmd_done_o === 1'b1) begin
         mst = exp_q.pop_front();
         chk(dbg_cmd_status_o, mst, "status");
         if (mst != `CMSC_ST_STOPWAIT_ERR) chk(dbg_cmd_accept_o, mst == `CMSC_ST_OK, "accept");
      end
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      error_cnt++;
      finish_test;
   end
   initial begin
      {rst_n_i, secure_i, irq_pending_i, periodic_wake_i, stop_clocks_keep_cfg_i, debug_enable_set_i, evt} = '0;
      {mem_req_i, mem_we_i, mem_fetch_i, mem_dbg_i, mem_stacking_i, mem_addr_i, mem_rdata_array_i} = '0;
      {opcode_i, opcode_prefixed_i, ce_i, debug_mode_select_pin_i, tag} = {10'h001, 1'b1, 1'b0};
      rst(1'b1);
      wmode(`CMSC_MODE_RUN);
      chk(opcode_valid_o, 1'b1, "opcode");
      @(posedge clk_sys_i);
      opcode_i <= `CMSC_OPC_PREFIX;
      @(negedge clk_sys_i);
      chk(opcode_valid_o, 1'b0, "prefix");
      @(posedge clk_sys_i);
      opcode_i <= 8'h00;
      for (int c = 0; c < 8; c++) if (c != 3) cmd(4'(c), 1'b1);
      cmd(`CMSC_CMD_HALT, 1'b0);
      for (int c = 0; c < 7; c++) cmd(4'(c), 1'b0);
      cmd(`CMSC_CMD_HALT, 1'b0);
      cmd(`CMSC_CMD_TAG_RESUME, 1'b0);
      for (int k = 1; k < 3; k++) begin
         ev(4'(k));
         wmode(`CMSC_MODE_HALT);
         cmd(`CMSC_CMD_RESUME, 1'b0);
      end
      ev(4'h8);
      wmode(`CMSC_MODE_WAIT);
      chk(cpu_clk_en_o, 1'b0, "clk_en");
      for (int c = 0; c < 4; c++) cmd(4'(c), 1'b0);
      cmd(`CMSC_CMD_RESUME, 1'b0);
      ev(4'h8);
      wmode(`CMSC_MODE_WAIT);
      @(posedge clk_sys_i);
      irq_pending_i <= 1'b1;
      wmode(`CMSC_MODE_RUN);
      chk(cpu_clk_en_o, 1'b1, "clk_en");
      @(posedge clk_sys_i);
      {irq_pending_i, stop_clocks_keep_cfg_i, debug_enable_set_i} <= 3'h3;
      @(posedge clk_sys_i);
      debug_enable_set_i <= 1'b0;
      ev(4'h4);
      wmode(`CMSC_MODE_STOP);
      chk(osc_keep_o, 1'b1, "osc");
      chk(stop_min_clk_o, 1'b1, "min_clk");
      cmd(`CMSC_CMD_MEM_STAT, 1'b0);
      cmd(`CMSC_CMD_HALT, 1'b0);
      cmd(`CMSC_CMD_RESUME, 1'b0);
      for (int i = 0; i < 64; i++) begin
         lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         a = lfsr[17] ? {lfsr[16] ? 8'h18 : 8'h00, lfsr[7:0]} : lfsr[31:16];
         f = (i % 32 == 0) ? 4'h4 : lfsr[11:8];
         f[3] = f[3] & ~f[2];
         sc = i >= 32;
         // secure pin crosses two flops before the gating sees it
         if (i == 32) begin
            @(posedge clk_sys_i);
            secure_i <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
         end
         acc(a, f, sc);
      end
      rst(1'b0);
      wmode(`CMSC_MODE_HALT);
      chk(debug_enable_o, 1'b1, "dbg_en");
      finish_test;
   end
endmodule
bind cmsc_core cmsc_core_chk #(.DP_TOP(DP_TOP), .HP_BASE(HP_BASE), .HP_TOP(HP_TOP)) u_chk (.*);
